// ---- shared/fcal_defs.vh ----
// constants and register map of the fan control and alarm block
//
// How it works
// - three separate fan drive outputs, each a 4-bit code.
// - drive level is analog supply times code over sixteen.
// - drive code registers reset to upper nibble all ones, full level.
// - entering either cruise mode drives the fan at full speed first.
// - thermal cruise: fan off below target, start level once above high limit.
// - above high limit level climbs; full for three minutes raises warning.
// - between low and high limits the level is held.
// - below low limit the level falls step by step toward zero.
// - minimum-speed enable stops the fall at the per-fan stop value.
// - speed cruise holds inside target band, raises above, lowers below.
// - manual mode drives the software-written code directly.
// - pin carries the management interrupt only when selected, else alternate input.
// - voltage and fan events interrupt only after all status was read.
// - first sensor: hysteresis at maximum selects comparator, else interrupt mode.
// - first sensor comparator repeats each conversion while above limit once cleared.
// - first sensor interrupt mode picks one-time or two-times by a bit.
// - two-times: interrupt on exceeding limit and again below hysteresis.
// - one-time: interrupt only on exceeding limit, none below hysteresis.
// - second and third sensors share one comparator or two-times bit.
// - their comparator mode repeats after each conversion until below hysteresis.
// - per-sensor bits select comparator or interrupt mode for the alarm output.
// - comparator alarm output: set above limit, held until below hysteresis.
// - interrupt alarm output latches on crossings until temperature is read.
// - management interrupt driven only while its enable bit is one.
// - polarity bit: alarm output active high when one, low when zero.
`ifndef FCAL_DEFS_VH
`define FCAL_DEFS_VH
// register indices
`define FCAL_A_CFG 8'h00
`define FCAL_A_STAT1 8'h01
`define FCAL_A_STAT2 8'h02
`define FCAL_A_MASK1 8'h03
`define FCAL_A_MASK2 8'h04
`define FCAL_A_ALARM 8'h05
`define FCAL_A_OVTMODE 8'h06
`define FCAL_A_FANMODE 8'h07
`define FCAL_A_MINEN 8'h08
`define FCAL_A_LIVE0 8'h09
`define FCAL_A_FAN0 8'h10
`define FCAL_A_FANEND 8'h1B
// reset values
`define FCAL_RST_CFG 8'h03
`define FCAL_RST_MASK 8'h00
`define FCAL_RST_DRIVE 8'hF0
// field positions
`define FCAL_CFG_SMI_EN 1
`define FCAL_CFG_PIN_SEL 2
`define FCAL_AL_POL 2
`define FCAL_AL_ONETIME 5
`define FCAL_AL_COMP23 6
// codes
`define FCAL_FULL 4'hF
`define FCAL_HYST_MAX 8'h7F
`define FCAL_M_MANUAL 2'h0
`define FCAL_M_THERMAL 2'h1
`define FCAL_M_SPEED 2'h2
`define FCAL_T_COMP 2'h0
`define FCAL_T_TWO 2'h1
`define FCAL_T_ONE 2'h2
// timing
`define FCAL_WARN_MIN 36'h0_0000_0003
`define FCAL_CLK_HZ 36'h0_0EE6_B280
`endif

// ---- core/fcal_cruise.v ----
// one fan drive channel: manual, thermal cruise and speed cruise
`include "fcal_defs.vh"
`default_nettype none
module fcal_cruise #(
    parameter [35:0] WARN_CYCLES = 36'h0_0000_0010
) (
    input wire clk_i,
    input wire rst_i,
    input wire step_i,
    input wire [1:0] mode_i,
    input wire [7:0] temp_i,
    input wire [7:0] tach_i,
    input wire [7:0] target_i,
    input wire [7:0] tol_i,
    input wire [3:0] start_i,
    input wire [3:0] stop_i,
    input wire min_en_i,
    input wire [3:0] manual_i,
    output wire [3:0] code_o,
    output wire warn_o
);
    reg [3:0] code_r;
    reg on_r;
    reg [1:0] mode_q_r;
    reg [35:0] warn_cnt_r;
    reg warn_r;
    wire signed [9:0] t_s = {{2{temp_i[7]}}, temp_i};
    wire signed [9:0] tg_s = {{2{target_i[7]}}, target_i};
    wire signed [9:0] hi_s = tg_s + $signed({2'h0, tol_i});
    wire signed [9:0] lo_s = tg_s - $signed({2'h0, tol_i});
    wire [8:0] s_hi = {1'b0, target_i} + {1'b0, tol_i};
    wire [8:0] s_lo = (tol_i > target_i) ? 9'h000 : {1'b0, target_i} - {1'b0, tol_i};
    wire above = t_s > hi_s;
    wire below = t_s < lo_s;
    wire [3:0] floor_c = min_en_i ? stop_i : 4'h0;
    wire [3:0] up_c = (code_r == `FCAL_FULL) ? code_r : code_r + 4'h1;
    wire [3:0] dn_c = (code_r <= floor_c) ? floor_c : code_r - 4'h1;
    wire hot_full = (mode_i == `FCAL_M_THERMAL) && on_r && above && (code_r == `FCAL_FULL);

    // drive code regulation
    always @(posedge clk_i) begin
        if (rst_i) begin
            code_r <= `FCAL_FULL;
            on_r <= 1'b0;
            mode_q_r <= `FCAL_M_MANUAL;
        end else begin
            mode_q_r <= mode_i;
            if (mode_i != mode_q_r) begin
                code_r <= (mode_i == `FCAL_M_MANUAL) ? manual_i : `FCAL_FULL;
                on_r <= 1'b0;
            end else begin
                case (mode_i)
                    `FCAL_M_THERMAL: begin
                        if (step_i) begin
                            if (!on_r) begin
                                if (above) begin
                                    code_r <= start_i;
                                    on_r <= 1'b1;
                                end else if (t_s < tg_s) begin
                                    code_r <= 4'h0;
                                end
                            end else if (above) begin
                                code_r <= up_c;
                            end else if (below) begin
                                code_r <= dn_c;
                            end
                        end
                    end
                    `FCAL_M_SPEED: begin
                        if (step_i) begin
                            if ({1'b0, tach_i} > s_hi) begin
                                code_r <= up_c;
                            end else if ({1'b0, tach_i} < s_lo) begin
                                code_r <= dn_c;
                            end
                        end
                    end
                    default: begin
                        code_r <= manual_i;
                    end
                endcase
            end
        end
    end

    // full-speed overheat timer, one pulse per episode
    always @(posedge clk_i) begin
        if (rst_i) begin
            warn_cnt_r <= 36'h0_0000_0000;
            warn_r <= 1'b0;
        end else begin
            warn_r <= 1'b0;
            if (!hot_full) begin
                warn_cnt_r <= 36'h0_0000_0000;
            end else if (warn_cnt_r < WARN_CYCLES) begin
                warn_cnt_r <= warn_cnt_r + 36'h0_0000_0001;
                warn_r <= (warn_cnt_r == WARN_CYCLES - 36'h0_0000_0001);
            end
        end
    end

    assign code_o = code_r;
    assign warn_o = warn_r;
endmodule
`default_nettype wire

// ---- core/fcal_talarm.v ----
// one temperature sensor: interrupt event and over-temperature latch
`include "fcal_defs.vh"
`default_nettype none
module fcal_talarm (
    input wire clk_i,
    input wire rst_i,
    input wire step_i,
    input wire [7:0] temp_i,
    input wire [7:0] over_i,
    input wire [7:0] rel_i,
    input wire [7:0] hyst_i,
    input wire [1:0] mode_i,
    input wire clr_i,
    input wire ovt_int_i,
    input wire temp_rd_i,
    output wire evt_o,
    output wire ovt_o
);
    reg hot_r;
    reg pend_r;
    reg evt_r;
    reg ohot_r;
    reg olat_r;
    wire gt_over = $signed(temp_i) > $signed(over_i);
    wire lt_rel = $signed(temp_i) < $signed(rel_i);
    wire lt_hyst = $signed(temp_i) < $signed(hyst_i);
    reg fire;

    // event decision per conversion
    always @* begin
        fire = 1'b0;
        if (step_i && !pend_r) begin
            case (mode_i)
                `FCAL_T_COMP: fire = gt_over || (hot_r && !lt_rel);
                `FCAL_T_TWO: fire = (!hot_r && gt_over) || (hot_r && lt_hyst);
                `FCAL_T_ONE: fire = !hot_r && gt_over;
                default: fire = 1'b0;
            endcase
        end
    end

    // interrupt state, set wins over clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            hot_r <= 1'b0;
            pend_r <= 1'b0;
            evt_r <= 1'b0;
        end else begin
            evt_r <= fire;
            if (step_i) begin
                if (gt_over) begin
                    hot_r <= 1'b1;
                end else if (mode_i == `FCAL_T_COMP ? lt_rel : lt_hyst) begin
                    hot_r <= 1'b0;
                end
            end
            if (fire) begin
                pend_r <= 1'b1;
            end else if (clr_i) begin
                pend_r <= 1'b0;
            end
        end
    end

    // over-temperature output state
    always @(posedge clk_i) begin
        if (rst_i) begin
            ohot_r <= 1'b0;
            olat_r <= 1'b0;
        end else begin
            if (step_i && gt_over) begin
                ohot_r <= 1'b1;
            end else if (step_i && lt_hyst) begin
                ohot_r <= 1'b0;
            end
            if (step_i && ((!ohot_r && gt_over) || (ohot_r && lt_hyst))) begin
                olat_r <= 1'b1;
            end else if (temp_rd_i) begin
                olat_r <= 1'b0;
            end
        end
    end

    assign evt_o = evt_r;
    assign ovt_o = ovt_int_i ? olat_r : ohot_r;
endmodule
`default_nettype wire

// ---- core/fcal_top.v ----
// fan control and alarm block with its register port
`include "fcal_defs.vh"
`default_nettype none
module fcal_top #(
    parameter [35:0] WARN_CYCLES = `FCAL_WARN_MIN * 36'h0_0000_003C * `FCAL_CLK_HZ
) (
    input wire clk_i,
    input wire rst_i,
    // register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [7:0] rdata_o,
    // monitored values
    input wire conv_done_i,
    input wire [7:0] system_temp_input_i,
    input wire [7:0] processor_temp_input_i,
    input wire [7:0] auxiliary_temp_input_i,
    input wire [7:0] system_fan_tach_i,
    input wire [7:0] processor_fan_tach_i,
    input wire [7:0] auxiliary_fan_tach_i,
    input wire [23:0] over_limit_i,
    input wire [23:0] hysteresis_limit_i,
    input wire [23:0] fan_count_limit_i,
    input wire [3:0] volt_out_of_range_i,
    input wire [2:0] temp_read_i,
    // pins
    output wire [3:0] system_fan_drive_o,
    output wire [3:0] processor_fan_drive_o,
    output wire [3:0] auxiliary_fan_drive_o,
    input wire system_mgmt_interrupt_pin_i,
    output wire system_mgmt_interrupt_out_n_o,
    output wire system_mgmt_interrupt_out_oe_o,
    output wire alternate_irq_input_o,
    output wire overtemp_alarm_out_o
);
    // control registers
    reg [7:0] cfg_r;
    reg [7:0] mask1_r;
    reg [7:0] mask2_r;
    reg [7:0] alarm_r;
    reg [2:0] ovtmode_r;
    reg [5:0] fanmode_r;
    reg [2:0] minen_r;
    reg [7:0] fan_r [0:11];
    // status and interrupt state
    reg [7:0] stat1_r;
    reg [7:0] stat2_r;
    reg rd1_seen_r;
    reg rd2_seen_r;
    reg clr_all_r;
    reg [6:0] vf_q_r;
    reg vf_pend_r;
    reg [7:0] rdata_r;
    reg smi_oe_r;
    reg alt_irq_r;
    reg ovt_r;

    // fan register address decode
    function fan_hit;
        input [7:0] a;
        begin
            fan_hit = (a >= `FCAL_A_FAN0) && (a <= `FCAL_A_FANEND);
        end
    endfunction

    function [3:0] fan_idx;
        input [7:0] a;
        reg [7:0] d;
        begin
            d = a - `FCAL_A_FAN0;
            fan_idx = d[3:0];
        end
    endfunction

    wire step = conv_done_i && cfg_r[0];
    wire [23:0] temps = {auxiliary_temp_input_i, processor_temp_input_i, system_temp_input_i};
    wire [23:0] tachs = {auxiliary_fan_tach_i, processor_fan_tach_i, system_fan_tach_i};
    wire [11:0] codes;
    wire [2:0] warns;
    wire [2:0] tevt;
    wire [2:0] tovt;

    // three fan drive channels
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : ch
            wire [7:0] drv = fan_r[4 * g];
            wire [7:0] ss = fan_r[4 * g + 3];
            fcal_cruise #(
                .WARN_CYCLES(WARN_CYCLES)
            ) u_cruise (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .step_i(step),
                .mode_i(fanmode_r[2 * g +: 2]),
                .temp_i(temps[8 * g +: 8]),
                .tach_i(tachs[8 * g +: 8]),
                .target_i(fan_r[4 * g + 1]),
                .tol_i(fan_r[4 * g + 2]),
                .start_i(ss[7:4]),
                .stop_i(ss[3:0]),
                .min_en_i(minen_r[g]),
                .manual_i(drv[7:4]),
                .code_o(codes[4 * g +: 4]),
                .warn_o(warns[g])
            );
        end
    endgenerate

    // temperature alarm modes per sensor
    wire s0_comp = hysteresis_limit_i[7:0] == `FCAL_HYST_MAX;
    wire [1:0] s0_mode = s0_comp ? `FCAL_T_COMP :
        (alarm_r[`FCAL_AL_ONETIME] ? `FCAL_T_ONE : `FCAL_T_TWO);
    wire [1:0] s12_mode = alarm_r[`FCAL_AL_COMP23] ? `FCAL_T_COMP : `FCAL_T_TWO;
    wire [7:0] s0_rel = s0_comp ? over_limit_i[7:0] : hysteresis_limit_i[7:0];

    generate
        for (g = 0; g < 3; g = g + 1) begin : ta
            fcal_talarm u_alarm (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .step_i(step),
                .temp_i(temps[8 * g +: 8]),
                .over_i(over_limit_i[8 * g +: 8]),
                .rel_i(g == 0 ? s0_rel : hysteresis_limit_i[8 * g +: 8]),
                .hyst_i(hysteresis_limit_i[8 * g +: 8]),
                .mode_i(g == 0 ? s0_mode : s12_mode),
                .clr_i(clr_all_r),
                .ovt_int_i(ovtmode_r[g]),
                .temp_rd_i(temp_read_i[g]),
                .evt_o(tevt[g]),
                .ovt_o(tovt[g])
            );
        end
    endgenerate

    // voltage and fan limit levels, events on change
    wire [2:0] fan_over;
    generate
        for (g = 0; g < 3; g = g + 1) begin : fo
            assign fan_over[g] = tachs[8 * g +: 8] > fan_count_limit_i[8 * g +: 8];
        end
    endgenerate
    wire [6:0] vf_now = {fan_over, volt_out_of_range_i};
    wire [6:0] vf_chg = (vf_now ^ vf_q_r) & {7{step && !vf_pend_r}};

    // register writes
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= `FCAL_RST_CFG;
            mask1_r <= `FCAL_RST_MASK;
            mask2_r <= `FCAL_RST_MASK;
            alarm_r <= 8'h00;
            ovtmode_r <= 3'h0;
            fanmode_r <= 6'h00;
            minen_r <= 3'h0;
            for (i = 0; i < 12; i = i + 1) begin
                fan_r[i] <= (i % 4 == 0) ? `FCAL_RST_DRIVE : 8'h00;
            end
        end else if (wr_i) begin
            case (addr_i)
                `FCAL_A_CFG: cfg_r <= wdata_i;
                `FCAL_A_MASK1: mask1_r <= wdata_i;
                `FCAL_A_MASK2: mask2_r <= wdata_i;
                `FCAL_A_ALARM: alarm_r <= wdata_i;
                `FCAL_A_OVTMODE: ovtmode_r <= wdata_i[2:0];
                `FCAL_A_FANMODE: fanmode_r <= wdata_i[5:0];
                `FCAL_A_MINEN: minen_r <= wdata_i[2:0];
                default: begin
                    if (fan_hit(addr_i)) begin
                        fan_r[fan_idx(addr_i)] <= wdata_i;
                    end
                end
            endcase
        end
    end

    // sticky status, read clears, set wins
    wire rd1 = rd_i && (addr_i == `FCAL_A_STAT1);
    wire rd2 = rd_i && (addr_i == `FCAL_A_STAT2);
    wire [7:0] set1 = {tevt[0], vf_chg};
    wire [7:0] set2 = {3'h0, warns, tevt[2:1]};
    always @(posedge clk_i) begin
        if (rst_i) begin
            stat1_r <= 8'h00;
            stat2_r <= 8'h00;
            vf_q_r <= 7'h00;
            vf_pend_r <= 1'b0;
            rd1_seen_r <= 1'b0;
            rd2_seen_r <= 1'b0;
            clr_all_r <= 1'b0;
        end else begin
            stat1_r <= (rd1 ? 8'h00 : stat1_r) | set1;
            stat2_r <= (rd2 ? 8'h00 : stat2_r) | set2;
            if (step) begin
                vf_q_r <= vf_now;
            end
            clr_all_r <= 1'b0;
            if ((rd1 || rd1_seen_r) && (rd2 || rd2_seen_r)) begin
                rd1_seen_r <= 1'b0;
                rd2_seen_r <= 1'b0;
                clr_all_r <= 1'b1;
            end else begin
                rd1_seen_r <= rd1_seen_r || rd1;
                rd2_seen_r <= rd2_seen_r || rd2;
            end
            if (|vf_chg) begin
                vf_pend_r <= 1'b1;
            end else if (clr_all_r) begin
                vf_pend_r <= 1'b0;
            end
        end
    end

    // read data, one cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `FCAL_A_CFG: rdata_r <= cfg_r;
                `FCAL_A_STAT1: rdata_r <= stat1_r;
                `FCAL_A_STAT2: rdata_r <= stat2_r;
                `FCAL_A_MASK1: rdata_r <= mask1_r;
                `FCAL_A_MASK2: rdata_r <= mask2_r;
                `FCAL_A_ALARM: rdata_r <= alarm_r;
                `FCAL_A_OVTMODE: rdata_r <= {5'h00, ovtmode_r};
                `FCAL_A_FANMODE: rdata_r <= {2'h0, fanmode_r};
                `FCAL_A_MINEN: rdata_r <= {5'h00, minen_r};
                default: begin
                    if (fan_hit(addr_i)) begin
                        rdata_r <= fan_r[fan_idx(addr_i)];
                    end else if (addr_i >= `FCAL_A_LIVE0 && addr_i < `FCAL_A_FAN0 &&
                                 addr_i - `FCAL_A_LIVE0 < 8'h03) begin
                        rdata_r <= {codes[4 * (addr_i - `FCAL_A_LIVE0) +: 4], 4'h0};
                    end else begin
                        rdata_r <= 8'h00;
                    end
                end
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // interrupt pin and alarm output
    wire smi_src = |(stat1_r & ~mask1_r) || |(stat2_r & ~mask2_r);
    always @(posedge clk_i) begin
        if (rst_i) begin
            smi_oe_r <= 1'b0;
            alt_irq_r <= 1'b0;
            ovt_r <= 1'b1;
        end else begin
            smi_oe_r <= cfg_r[`FCAL_CFG_PIN_SEL] && cfg_r[`FCAL_CFG_SMI_EN] && smi_src;
            alt_irq_r <= !cfg_r[`FCAL_CFG_PIN_SEL] && system_mgmt_interrupt_pin_i;
            ovt_r <= alarm_r[`FCAL_AL_POL] ? (|tovt) : !(|tovt);
        end
    end

    // drive codes go to the 4-bit converters, level = supply * code / 16
    reg [11:0] codes_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            codes_r <= 12'hFFF;
        end else begin
            codes_r <= codes;
        end
    end

    assign system_fan_drive_o = codes_r[3:0];
    assign processor_fan_drive_o = codes_r[7:4];
    assign auxiliary_fan_drive_o = codes_r[11:8];
    assign rdata_o = rdata_r;
    assign system_mgmt_interrupt_out_n_o = 1'b0;
    assign system_mgmt_interrupt_out_oe_o = smi_oe_r;
    assign alternate_irq_input_o = alt_irq_r;
    assign overtemp_alarm_out_o = ovt_r;
endmodule
`default_nettype wire

// ---- tb/fcal_assertions.sv ----
// port-level properties of the fan control and alarm block
`default_nettype none
module fcal_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic conv_done_i,
    input wire logic [2:0] temp_read_i,
    input wire logic [3:0] system_fan_drive_o,
    input wire logic system_mgmt_interrupt_pin_i,
    input wire logic system_mgmt_interrupt_out_n_o,
    input wire logic system_mgmt_interrupt_out_oe_o,
    input wire logic alternate_irq_input_o,
    input wire logic overtemp_alarm_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] hist_r;
    // recent causes that may move a drive code or the alarm pin
    always @(posedge clk_i) begin
        hist_r <= {hist_r[1:0], conv_done_i | wr_i | (|temp_read_i)};
    end
    // register port and pin relations
    a_read_window: assert property (rdata_o != 8'h00 |-> $past(rd_i))
        else $error("read data outside read slot");
    a_smi_open_drain: assert property (system_mgmt_interrupt_out_n_o == 1'b0)
        else $error("interrupt pin data not low");
    a_pin_mode_excl: assert property (
        !(system_mgmt_interrupt_out_oe_o && alternate_irq_input_o))
        else $error("pin both interrupt and alternate input");
    a_alt_from_pin: assert property (
        alternate_irq_input_o |-> $past(system_mgmt_interrupt_pin_i))
        else $error("alternate input not from pin");
    a_reset_drive: assert property (disable iff (1'b0)
        rst_i |=> system_fan_drive_o == 4'hF)
        else $error("drive not full after reset");
    a_reset_alarm: assert property (disable iff (1'b0)
        rst_i |=> overtemp_alarm_out_o && !system_mgmt_interrupt_out_oe_o)
        else $error("alarm or interrupt active after reset");
    a_drive_cause: assert property (!$stable(system_fan_drive_o) |-> hist_r != 3'h0)
        else $error("drive moved without step or write");
    a_alarm_cause: assert property (!$stable(overtemp_alarm_out_o) |-> hist_r != 3'h0)
        else $error("alarm moved without cause");
endmodule
`default_nettype wire

// ---- tb/fcal_plant.sv ----
// behavioural fans: tach count falls as the drive code rises
`default_nettype none
module fcal_plant (
    input wire logic clk_i,
    input wire logic [11:0] drv_i,
    output var logic [23:0] tach_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // fan speed settles one clock after the drive code changes
    always @(posedge clk_i) begin
        for (int n = 0; n < 3; n++) begin
            tach_o[n*8 +: 8] <= 8'hF0 - {drv_i[n*4 +: 4], 4'h0};
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_fcal_top.sv ----
// self-checking bench for the fan control and alarm block
`default_nettype none
module tb_fcal_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, conv = 0, pin = 0;
    logic [7:0] a = 0, wd = 0, t0 = 0, ov0 = 8'h7F, hy0 = 8'h7E, d, v, rdat;
    logic [3:0] volt = 0;
    logic [2:0] trd = 0;
    logic [11:0] drv;
    logic [23:0] tach;
    logic n_o, oe, alt, ovt;
    integer fail_count = 0, checks_done = 0, seed = 94129, i;
    fcal_top #(.WARN_CYCLES(36'h0_0000_0014)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdat), .conv_done_i(conv), .system_temp_input_i(t0),
        .processor_temp_input_i({4'h0, volt}), .auxiliary_temp_input_i({4'h0, volt}),
        .system_fan_tach_i(tach[7:0]), .processor_fan_tach_i(tach[15:8]),
        .auxiliary_fan_tach_i(tach[23:16]), .over_limit_i({16'h7F7F, ov0}),
        .hysteresis_limit_i({16'h7E7E, hy0}), .fan_count_limit_i(24'hFF_FFFF),
        .volt_out_of_range_i(volt), .temp_read_i(trd),
        .system_fan_drive_o(drv[3:0]), .processor_fan_drive_o(drv[7:4]),
        .auxiliary_fan_drive_o(drv[11:8]), .system_mgmt_interrupt_pin_i(pin),
        .system_mgmt_interrupt_out_n_o(n_o), .system_mgmt_interrupt_out_oe_o(oe),
        .alternate_irq_input_o(alt), .overtemp_alarm_out_o(ovt));
    fcal_plant u_plant (.clk_i(clk_i), .drv_i(drv), .tach_o(tach));
    // clock and watchdog
    initial forever #2 clk_i = ~clk_i;
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        finish_test;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrr(input logic [7:0] ad, input logic [7:0] val);
        @(posedge clk_i);
        a <= ad;
        wd <= val;
        wr <= 1;
        @(posedge clk_i);
        wr <= 0;
    endtask
    task automatic rdr(input logic [7:0] ad);
        @(posedge clk_i);
        a <= ad;
        rd <= 1;
        @(posedge clk_i);
        rd <= 0;
        #1 d = rdat;
    endtask
    task automatic sb(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
        rdr(ad);
        chk(d & m, e);
    endtask
    task automatic clr;
        rdr(8'h01);
        rdr(8'h02);
    endtask
    // one-cycle host read of the first temperature register
    task automatic trp;
        @(posedge clk_i);
        trd <= 3'h1;
        @(posedge clk_i);
        trd <= 3'h0;
    endtask
    // one conversion with a new sensor reading
    task automatic stp(input logic [7:0] t);
        @(posedge clk_i);
        t0 <= t;
        conv <= 1;
        @(posedge clk_i);
        conv <= 0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    function automatic logic [7:0] code(input logic [3:0] c);
        return {4'h0, c};
    endfunction
    task automatic finish_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        rdr(8'h00);
        chk(d, 8'h03);
        chk(drv[7:0], 8'hFF);
        chk({drv[11:8], 3'h0, ovt}, 8'hF1);
        rdr(8'h0C);
        chk(d, 8'h00);
        for (i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wrr(8'h10 + 8'(4 * (i % 3)), v);
            rdr(8'h09 + 8'(i % 3));
            chk(d, {v[7:4], 4'h0});
            chk(code(drv[(i % 3) * 4 +: 4]), code(v[7:4]));
        end
        wrr(8'h15, 8'h80);
        wrr(8'h16, 8'h08);
        wrr(8'h07, 8'h08);
        settle;
        chk(code(drv[7:4]), code(4'hF));
        stp(8'h00);
        chk(code(drv[7:4]), code(4'hE));
        repeat (11) stp(8'h00);
        chk(code(drv[7:4]), code(4'h7));
        wrr(8'h11, 8'h32);
        wrr(8'h12, 8'h03);
        wrr(8'h13, 8'h62);
        wrr(8'h07, 8'h09);
        settle;
        chk(code(drv[3:0]), code(4'hF));
        repeat (16) stp(8'h28);
        chk(code(drv[3:0]), code(4'h0));
        stp(8'h3C);
        chk(code(drv[3:0]), code(4'h6));
        stp(8'h3C);
        chk(code(drv[3:0]), code(4'h7));
        stp(8'h33);
        chk(code(drv[3:0]), code(4'h7));
        stp(8'h28);
        chk(code(drv[3:0]), code(4'h6));
        wrr(8'h08, 8'h01);
        repeat (5) stp(8'h28);
        chk(code(drv[3:0]), code(4'h2));
        repeat (19) stp(8'h3C);
        wrr(8'h00, 8'h07);
        settle;
        chk(code(oe), 8'h01);
        wrr(8'h00, 8'h05);
        settle;
        chk(code(oe), 8'h00);
        sb(8'h02, 8'h04, 8'h04);
        wrr(8'h00, 8'h03);
        pin <= 1;
        settle;
        chk(code(alt), 8'h01);
        wrr(8'h07, 8'h00);
        ov0 <= 8'h32;
        hy0 <= 8'h2D;
        clr;
        stp(8'h37);
        sb(8'h01, 8'h80, 8'h80);
        chk(code(ovt), 8'h00);
        clr;
        stp(8'h37);
        sb(8'h01, 8'h80, 8'h00);
        stp(8'h30);
        chk(code(ovt), 8'h00);
        stp(8'h28);
        sb(8'h01, 8'h80, 8'h80);
        chk(code(ovt), 8'h01);
        wrr(8'h05, 8'h04);
        settle;
        chk(code(ovt), 8'h00);
        wrr(8'h05, 8'h20);
        clr;
        stp(8'h37);
        sb(8'h01, 8'h80, 8'h80);
        clr;
        stp(8'h28);
        sb(8'h01, 8'h80, 8'h00);
        hy0 <= 8'h7F;
        clr;
        stp(8'h37);
        sb(8'h01, 8'h80, 8'h80);
        clr;
        stp(8'h37);
        sb(8'h01, 8'h80, 8'h80);
        volt <= 4'h1;
        clr;
        stp(8'h28);
        sb(8'h01, 8'h01, 8'h01);
        hy0 <= 8'h2D;
        wrr(8'h06, 8'h01);
        trp;
        stp(8'h37);
        chk(code(ovt), 8'h00);
        trp;
        stp(8'h37);
        chk(code(ovt), 8'h01);
        stp(8'h28);
        chk(code(ovt), 8'h00);
        finish_test;
    end
endmodule
bind fcal_top fcal_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .conv_done_i(conv_done_i), .temp_read_i(temp_read_i),
    .system_fan_drive_o(system_fan_drive_o),
    .system_mgmt_interrupt_pin_i(system_mgmt_interrupt_pin_i),
    .system_mgmt_interrupt_out_n_o(system_mgmt_interrupt_out_n_o),
    .system_mgmt_interrupt_out_oe_o(system_mgmt_interrupt_out_oe_o),
    .alternate_irq_input_o(alternate_irq_input_o),
    .overtemp_alarm_out_o(overtemp_alarm_out_o));
`default_nettype wire
